//--- src/ccac_consts.vh
// constants for the chopper and adaptive current configuration block
`ifndef CCAC_CONSTS_VH
`define CCAC_CONSTS_VH

// ==================================================
// parameter offsets
`define CCAC_OFS_INTERP      8'hA0
`define CCAC_OFS_DBL         8'hA1
`define CCAC_OFS_MASK_TIME   8'hA2
`define CCAC_OFS_CHOP_MODE   8'hA3
`define CCAC_OFS_FD_DIS      8'hA4
`define CCAC_OFS_HEND_FDT    8'hA5
`define CCAC_OFS_HSTRT_SOFS  8'hA6
`define CCAC_OFS_OFF_PERIOD  8'hA7
`define CCAC_OFS_MIN_CUR     8'hA8
`define CCAC_OFS_DOWN_RATE   8'hA9
`define CCAC_OFS_HYST_WIDTH  8'hAA
`define CCAC_OFS_UP_STEP     8'hAB
`define CCAC_OFS_LOW_THR     8'hAC
`define CCAC_OFS_FILTER      8'hAD
`define CCAC_OFS_STALL_THR   8'hAE
`define CCAC_OFS_BASE        8'hA0
`define CCAC_NUM_REGS        15
`define CCAC_IDX_NONE        4'hF

// ==================================================
// field widths as masks, indexed by offset minus base
`define CCAC_MASK_1          8'h01
`define CCAC_MASK_2          8'h03
`define CCAC_MASK_4          8'h0F
`define CCAC_MASK_7          8'h7F

// ==================================================
// reset values
`define CCAC_RST_DEFAULT     8'h00
`define CCAC_RST_MASK_TIME   8'h02

// ==================================================
// step and resolution figures
`define CCAC_RES_INTERP      4'h4
`define CCAC_RES_MAX         4'h8
`define CCAC_FINE_PER_FULL   10'h100
`define CCAC_INTERP_SUBSTEPS 8'h10
`define CCAC_SUB_PEND_MAX    8'hF0
`define CCAC_SUB_GAP         4

// ==================================================
// load handling figures
`define CCAC_THR_SHIFT       5
`define CCAC_STALL_SHIFT     4
`define CCAC_FILT_FULLSTEPS  3'h4
`define CCAC_FILT_DEPTH      4

// ==================================================
// comparator mask cycles per code
`define CCAC_BLANK_C0        16
`define CCAC_BLANK_C1        24
`define CCAC_BLANK_C2        36
`define CCAC_BLANK_C3        54

`endif

//--- src/ccac_blank.v
// comparator masking after each power stage switching event
`default_nettype none
`include "ccac_consts.vh"

module ccac_blank #(
    parameter [5:0] BLANK_C0 = `CCAC_BLANK_C0,
    parameter [5:0] BLANK_C1 = `CCAC_BLANK_C1,
    parameter [5:0] BLANK_C2 = `CCAC_BLANK_C2,
    parameter [5:0] BLANK_C3 = `CCAC_BLANK_C3
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [1:0] blank_sel_i,
    input wire sw_event_i,
    input wire cmp_raw_i,
    output wire cmp_o,
    output wire blank_o
);
    reg [5:0] cnt_q;
    reg [5:0] load_w;

    // mask length chosen by the two-bit code
    always @* begin
        case (blank_sel_i)
            2'h0: load_w = BLANK_C0;
            2'h1: load_w = BLANK_C1;
            2'h2: load_w = BLANK_C2;
            default: load_w = BLANK_C3;
        endcase
    end

    // restart the mask on every switching event
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= 6'h00;
        end else if (ce_i) begin
            if (sw_event_i) begin
                cnt_q <= load_w;
            end else if (cnt_q != 6'h00) begin
                cnt_q <= cnt_q - 6'h01;
            end
        end
    end

    // comparator is ignored while ringing may still be present
    assign blank_o = sw_event_i | (cnt_q != 6'h00);
    assign cmp_o = cmp_raw_i & ~blank_o;
endmodule
`default_nettype wire

//--- src/ccac_load_filt.v
// load reading filter: pass-through or one averaged reading per four fullsteps
`default_nettype none
`include "ccac_consts.vh"

module ccac_load_filt #(
    parameter W = 10
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire filt_en_i,
    input wire fullstep_i,
    input wire meas_valid_i,
    input wire [W-1:0] meas_i,
    output reg load_valid_o,
    output reg [W-1:0] load_o
);
    reg [W-1:0] hist_q [0:`CCAC_FILT_DEPTH-1];
    reg [2:0] fs_cnt_q;
    wire [W+1:0] sum_w;
    wire window_end_w;

    // history of the latest readings
    genvar g;
    generate
        for (g = 0; g < `CCAC_FILT_DEPTH; g = g + 1) begin : g_hist
            always @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    hist_q[g] <= {W{1'b0}};
                end else if (ce_i && meas_valid_i) begin
                    hist_q[g] <= (g == 0) ? meas_i : hist_q[(g == 0) ? 0 : g - 1];
                end
            end
        end
    endgenerate

    assign sum_w = {2'b00, hist_q[0]} + {2'b00, hist_q[1]} + {2'b00, hist_q[2]}
        + {2'b00, hist_q[3]};
    assign window_end_w = fullstep_i && (fs_cnt_q == `CCAC_FILT_FULLSTEPS - 3'h1);

    // output one reading per measurement, or one per four fullsteps
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            fs_cnt_q <= 3'h0;
            load_valid_o <= 1'b0;
            load_o <= {W{1'b0}};
        end else if (ce_i) begin
            load_valid_o <= 1'b0;
            if (fullstep_i) begin
                fs_cnt_q <= window_end_w ? 3'h0 : fs_cnt_q + 3'h1;
            end
            if (!filt_en_i) begin
                if (meas_valid_i) begin
                    load_valid_o <= 1'b1;
                    load_o <= meas_i;
                end
            end else if (window_end_w) begin
                load_valid_o <= 1'b1;
                load_o <= sum_w[W+1:2];
            end
        end
    end
endmodule
`default_nettype wire

//--- src/ccac_top.v
// chopper settings, step execution and load adaptive current regulation
`default_nettype none
`include "ccac_consts.vh"

// Function
// - interpolation on at 16 microsteps runs each step as 16 fine steps
// - doubling on executes two microsteps per step input pulse
// - with doubling both step input edges each execute a microstep
// - two-bit code sets comparator mask time after each switching event
// - mode bit 0 selects hysteresis chopper, 1 constant off time
// - in constant off time, disable bit stops comparator ending fast decay
// - shared field is hysteresis end or fast decay time; read returns it
// - second field is hysteresis start offset on end, or sine offset
// - minimum current bit picks half or quarter of maximum scale
// - decrement after 32, 8, 2 or 1 readings above upper threshold
// - upper threshold is (start plus width plus one) times 32
// - each reading below lower threshold increments by 1, 2, 4 or 8
// - start field times 32 is the lower threshold for increments
// - filter bit gives one load reading per four fullsteps
// - signed stall threshold -64 to 63; higher needs more torque
// - resolution code 0 to 8 is full to 256; code 4 is 16
// - adapted scale 1/32 to 32/32 between minimum portion and maximum
// - adaptation only above threshold speed; slow run current below
module ccac_top #(
    parameter SUB_GAP = `CCAC_SUB_GAP,
    parameter SPEED_W = 11
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire [7:0] par_addr_i,
    input wire [7:0] par_wdata_i,
    input wire par_wr_i,
    input wire par_rd_i,
    output reg [7:0] par_rdata_o,
    output reg par_ack_o,
    output reg par_err_o,
    input wire [3:0] mstep_res_i,
    input wire step_i,
    input wire dir_i,
    output reg [9:0] phase_pos_o,
    output reg ustep_o,
    output reg fullstep_o,
    input wire sw_event_i,
    input wire cmp_raw_i,
    output wire cmp_masked_o,
    output wire fd_term_o,
    output reg chop_mode_o,
    output reg [3:0] hyst_end_fdt_o,
    output reg [3:0] hyst_start_sofs_o,
    output reg [4:0] hyst_top_o,
    output reg [3:0] off_period_o,
    input wire meas_valid_i,
    input wire [9:0] meas_i,
    input wire [SPEED_W-1:0] speed_i,
    input wire [SPEED_W-1:0] thr_speed_i,
    input wire [4:0] cs_max_i,
    input wire [4:0] slowrun_cur_i,
    output reg [4:0] act_cur_o,
    output reg adapt_active_o,
    output reg [9:0] load_o,
    output reg stall_o
);
    // ==================================================
    // decode helpers

    // parameter offset to array index, none when unmapped
    function [3:0] ccac_idx;
        input [7:0] addr;
        begin
            if (addr >= `CCAC_OFS_INTERP && addr <= `CCAC_OFS_STALL_THR) begin
                ccac_idx = addr[3:0];
            end else begin
                ccac_idx = `CCAC_IDX_NONE;
            end
        end
    endfunction

    // stored width of each field
    function [7:0] ccac_mask;
        input [3:0] idx;
        begin
            case ({4'h0, idx} + `CCAC_OFS_BASE)
                `CCAC_OFS_MASK_TIME, `CCAC_OFS_DOWN_RATE, `CCAC_OFS_UP_STEP:
                    ccac_mask = `CCAC_MASK_2;
                `CCAC_OFS_HEND_FDT, `CCAC_OFS_HSTRT_SOFS, `CCAC_OFS_OFF_PERIOD,
                `CCAC_OFS_HYST_WIDTH, `CCAC_OFS_LOW_THR:
                    ccac_mask = `CCAC_MASK_4;
                `CCAC_OFS_STALL_THR:
                    ccac_mask = `CCAC_MASK_7;
                default:
                    ccac_mask = `CCAC_MASK_1;
            endcase
        end
    endfunction

    // ==================================================
    // parameter store

    reg [7:0] cfg_q [0:`CCAC_NUM_REGS-1];
    wire [3:0] wr_idx_w;
    wire [3:0] rd_idx_w;

    assign wr_idx_w = ccac_idx(par_addr_i);
    assign rd_idx_w = ccac_idx(par_addr_i);

    // one stored field per offset, written at its own width
    genvar g;
    generate
        for (g = 0; g < `CCAC_NUM_REGS; g = g + 1) begin : g_cfg
            localparam [3:0] IDX = g;
            always @(posedge sys_clk_i) begin
                if (!rst_b_i) begin
                    cfg_q[g] <= (g == 2) ? `CCAC_RST_MASK_TIME : `CCAC_RST_DEFAULT;
                end else if (ce_i && par_wr_i && wr_idx_w == IDX) begin
                    cfg_q[g] <= par_wdata_i & ccac_mask(IDX);
                end
            end
        end
    endgenerate

    // field views
    wire interp_en_w = cfg_q[0][0];
    wire dbl_en_w = cfg_q[1][0];
    wire [1:0] mask_time_w = cfg_q[2][1:0];
    wire mode_w = cfg_q[3][0];
    wire fd_dis_w = cfg_q[4][0];
    wire min_sel_w = cfg_q[8][0];
    wire [1:0] down_rate_w = cfg_q[9][1:0];
    wire [3:0] hyst_w = cfg_q[10][3:0];
    wire [1:0] up_step_w = cfg_q[11][1:0];
    wire [3:0] low_thr_w = cfg_q[12][3:0];
    wire filt_en_w = cfg_q[13][0];
    wire [6:0] stall_thr_w = cfg_q[14][6:0];

    // answer every access one cycle later; unmapped reads return zero
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            par_rdata_o <= 8'h00;
            par_ack_o <= 1'b0;
            par_err_o <= 1'b0;
        end else if (ce_i) begin
            par_ack_o <= par_wr_i | par_rd_i;
            par_err_o <= (par_wr_i | par_rd_i) && rd_idx_w == `CCAC_IDX_NONE;
            if (par_rd_i) begin
                par_rdata_o <= (rd_idx_w == `CCAC_IDX_NONE) ? 8'h00 : cfg_q[rd_idx_w];
            end
        end
    end

    // ==================================================
    // chopper settings to the power stage

    // registered chopper configuration
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            chop_mode_o <= 1'b0;
            hyst_end_fdt_o <= 4'h0;
            hyst_start_sofs_o <= 4'h0;
            hyst_top_o <= 5'h00;
            off_period_o <= 4'h0;
        end else if (ce_i) begin
            chop_mode_o <= mode_w;
            hyst_end_fdt_o <= cfg_q[5][3:0];
            hyst_start_sofs_o <= cfg_q[6][3:0];
            hyst_top_o <= mode_w ? 5'h00 : cfg_q[5][4:0] + cfg_q[6][4:0];
            off_period_o <= cfg_q[7][3:0];
        end
    end

    ccac_blank u_blank (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .blank_sel_i(mask_time_w),
        .sw_event_i(sw_event_i),
        .cmp_raw_i(cmp_raw_i),
        .cmp_o(cmp_masked_o),
        .blank_o()
    );

    // comparator may end fast decay unless disabled in off time mode
    assign fd_term_o = cmp_masked_o & ~(mode_w & fd_dis_w);

    // ==================================================
    // step execution

    reg step_d_q;
    reg [7:0] sub_pend_q;
    reg sub_dir_q;
    reg [3:0] gap_q;
    reg [9:0] phase_d;
    reg ustep_d;
    wire [3:0] res_w;
    wire [9:0] inc_w;
    wire interp_on_w;
    wire step_evt_w;
    wire sub_go_w;

    // codes above 256 microsteps are held at 256
    assign res_w = (mstep_res_i > `CCAC_RES_MAX) ? `CCAC_RES_MAX : mstep_res_i;
    assign inc_w = `CCAC_FINE_PER_FULL >> res_w;
    assign interp_on_w = interp_en_w && res_w == `CCAC_RES_INTERP;
    // both edges count while doubling
    assign step_evt_w = (step_i & ~step_d_q) | (dbl_en_w & ~step_i & step_d_q);
    assign sub_go_w = sub_pend_q != 8'h00 && gap_q == 4'h0 &&
        !(step_evt_w && !interp_on_w);

    // next fine position
    always @* begin
        phase_d = phase_pos_o;
        ustep_d = 1'b0;
        if (step_evt_w && !interp_on_w) begin
            phase_d = dir_i ? phase_pos_o + inc_w : phase_pos_o - inc_w;
            ustep_d = 1'b1;
        end else if (sub_go_w) begin
            phase_d = sub_dir_q ? phase_pos_o + 10'h001 : phase_pos_o - 10'h001;
            ustep_d = 1'b1;
        end
    end

    // fine position, pending sub-steps and their spacing
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            step_d_q <= 1'b0;
            sub_pend_q <= 8'h00;
            sub_dir_q <= 1'b0;
            gap_q <= 4'h0;
            phase_pos_o <= 10'h000;
            ustep_o <= 1'b0;
            fullstep_o <= 1'b0;
        end else if (ce_i) begin
            step_d_q <= step_i;
            phase_pos_o <= phase_d;
            ustep_o <= ustep_d;
            fullstep_o <= phase_d[9:8] != phase_pos_o[9:8];
            if (sub_go_w) begin
                gap_q <= SUB_GAP[3:0] - 4'h1;
            end else if (gap_q != 4'h0) begin
                gap_q <= gap_q - 4'h1;
            end
            if (step_evt_w && interp_on_w) begin
                sub_dir_q <= dir_i;
                sub_pend_q <= (sub_pend_q > `CCAC_SUB_PEND_MAX) ? sub_pend_q :
                    sub_pend_q + `CCAC_INTERP_SUBSTEPS - {7'h00, sub_go_w};
            end else if (sub_go_w) begin
                sub_pend_q <= sub_pend_q - 8'h01;
            end
        end
    end

    // ==================================================
    // load readings and adaptive current

    wire load_valid_w;
    wire [9:0] load_w;

    ccac_load_filt #(
        .W(10)
    ) u_filt (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .filt_en_i(filt_en_w),
        .fullstep_i(fullstep_o),
        .meas_valid_i(meas_valid_i),
        .meas_i(meas_i),
        .load_valid_o(load_valid_w),
        .load_o(load_w)
    );

    reg [5:0] down_cnt_q;
    reg [5:0] down_need_w;
    reg [5:0] cur_sum_w;
    reg [4:0] cur_d;
    reg [5:0] cnt_d;
    wire [10:0] low_lim_w;
    wire [10:0] up_lim_w;
    wire [5:0] min_p1_w;
    wire [4:0] min_cur_w;
    wire active_w;
    wire signed [11:0] stall_adj_w;

    // thresholds in load units
    assign low_lim_w = {7'h00, low_thr_w} << `CCAC_THR_SHIFT;
    assign up_lim_w = ({7'h00, low_thr_w} + {7'h00, hyst_w} + 11'h001)
        << `CCAC_THR_SHIFT;
    // lowest scale, half or quarter of the maximum
    assign min_p1_w = min_sel_w ? ({1'b0, cs_max_i} + 6'h01) >> 2 :
        ({1'b0, cs_max_i} + 6'h01) >> 1;
    assign min_cur_w = (min_p1_w == 6'h00) ? 5'h00 : min_p1_w[4:0] - 5'h01;
    assign active_w = speed_i > thr_speed_i;
    assign stall_adj_w = $signed({2'b00, load_w}) +
        ($signed({{5{stall_thr_w[6]}}, stall_thr_w}) <<< `CCAC_STALL_SHIFT);

    // readings needed per decrement
    always @* begin
        case (down_rate_w)
            2'h0: down_need_w = 6'h20;
            2'h1: down_need_w = 6'h08;
            2'h2: down_need_w = 6'h02;
            default: down_need_w = 6'h01;
        endcase
    end

    // next scale: step up, count toward a step down, stay within limits
    always @* begin
        cur_d = act_cur_o;
        cnt_d = down_cnt_q;
        cur_sum_w = {1'b0, act_cur_o} + (6'h01 << up_step_w);
        if (!active_w) begin
            cur_d = slowrun_cur_i;
            cnt_d = 6'h00;
        end else begin
            if (load_valid_w && {1'b0, load_w} < low_lim_w) begin
                cur_d = (cur_sum_w > {1'b0, cs_max_i}) ? cs_max_i : cur_sum_w[4:0];
                cnt_d = 6'h00;
            end else if (load_valid_w && {1'b0, load_w} > up_lim_w) begin
                if (down_cnt_q + 6'h01 >= down_need_w) begin
                    cur_d = (act_cur_o > min_cur_w) ? act_cur_o - 5'h01 : min_cur_w;
                    cnt_d = 6'h00;
                end else begin
                    cnt_d = down_cnt_q + 6'h01;
                end
            end
            if (cur_d > cs_max_i) begin
                cur_d = cs_max_i;
            end else if (cur_d < min_cur_w) begin
                cur_d = min_cur_w;
            end
        end
    end

    // scale, counter, stall flag; a reading is used in its valid cycle only
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            act_cur_o <= 5'h00;
            down_cnt_q <= 6'h00;
            adapt_active_o <= 1'b0;
            load_o <= 10'h000;
            stall_o <= 1'b0;
        end else if (ce_i) begin
            act_cur_o <= cur_d;
            down_cnt_q <= cnt_d;
            adapt_active_o <= active_w;
            if (load_valid_w) begin
                load_o <= load_w;
                stall_o <= stall_adj_w <= 12'sh000;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/ccac_assertions.sv
// port level checks for the chopper and adaptive current block
`default_nettype none
module ccac_assertions #(
    parameter SUB_GAP = 4,
    parameter SPEED_W = 11
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    input wire logic [7:0] par_addr_i,
    input wire logic par_wr_i,
    input wire logic par_rd_i,
    input wire logic par_ack_o,
    input wire logic par_err_o,
    input wire logic sw_event_i,
    input wire logic cmp_raw_i,
    input wire logic cmp_masked_o,
    input wire logic fd_term_o,
    input wire logic ustep_o,
    input wire logic [9:0] phase_pos_o,
    input wire logic [SPEED_W-1:0] speed_i,
    input wire logic [SPEED_W-1:0] thr_speed_i,
    input wire logic adapt_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // port checks
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_ack_follows: assert property (ce_i && (par_wr_i || par_rd_i) |=> par_ack_o)
        else $error("strobe without ack");
    a_err_unmapped: assert property (
        ce_i && (par_wr_i || par_rd_i) && !(par_addr_i inside {[8'hA0:8'hAE]})
        |=> par_ack_o && par_err_o)
        else $error("unmapped access without error");
    a_mask_event: assert property (sw_event_i |-> !cmp_masked_o)
        else $error("comparator passed in switching cycle");
    a_mask_hold: assert property (ce_i && sw_event_i |-> ##15 !cmp_masked_o)
        else $error("mask ended too early");
    a_raw_gate: assert property (cmp_masked_o |-> cmp_raw_i)
        else $error("masked comparator without raw level");
    a_fd_gate: assert property (fd_term_o |-> cmp_masked_o)
        else $error("fast decay ended without comparator");
    a_ustep_move: assert property (ustep_o |-> phase_pos_o != $past(phase_pos_o))
        else $error("step pulse without move");
    a_active_flag: assert property (
        ce_i |=> adapt_active_o == $past(speed_i > thr_speed_i))
        else $error("adaptive flag does not follow speed");
endmodule

bind ccac_top ccac_assertions #(.SUB_GAP(SUB_GAP), .SPEED_W(SPEED_W)) ccac_assertions_inst (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .par_addr_i(par_addr_i),
    .par_wr_i(par_wr_i), .par_rd_i(par_rd_i), .par_ack_o(par_ack_o), .par_err_o(par_err_o),
    .sw_event_i(sw_event_i), .cmp_raw_i(cmp_raw_i), .cmp_masked_o(cmp_masked_o),
    .fd_term_o(fd_term_o), .ustep_o(ustep_o), .phase_pos_o(phase_pos_o), .speed_i(speed_i),
    .thr_speed_i(thr_speed_i), .adapt_active_o(adapt_active_o));
`default_nettype wire

//--- verification/ccac_stage_model.sv
// power stage and coil sense model facing the block
`default_nettype none
module ccac_stage_model (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic sw_req_i,
    input wire logic over_i,
    input wire logic meas_req_i,
    input wire logic [9:0] meas_val_i,
    output var logic sw_event_o,
    output var logic cmp_raw_o,
    output var logic meas_valid_o,
    output var logic [9:0] meas_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // switching pulse, comparator level and load readings
    always @(posedge sys_clk_i) begin
        sw_event_o <= rst_b_i & sw_req_i;
        cmp_raw_o <= over_i;
        meas_valid_o <= rst_b_i & meas_req_i;
        if (!rst_b_i) begin
            meas_o <= 10'h155;
        end else if (meas_req_i) begin
            meas_o <= meas_val_i;
        end else begin
            meas_o <= ~meas_o; // stale reading never holds still
        end
    end
endmodule
`default_nettype wire

//--- verification/test_ccac_top.sv
// self-checking bench for the chopper and adaptive current block
`default_nettype none
`include "ccac_consts.vh"
module test_ccac_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, step = 1'b0;
    logic sw_req = 1'b0, over = 1'b0, m_req = 1'b0, dir = 1'b1, ce = 1'b1, re;
    logic [7:0] addr = 8'hA0, wdata = 8'h00, rq;
    logic [3:0] res = 4'h0;
    logic [9:0] m_val = 10'h000, p, dp;
    logic [10:0] speed = 11'h000;
    logic [4:0] expc;
    wire [7:0] rdata;
    wire ack, err, ustep, sw_ev, craw, cmask, fdt, cmode, aact, stall, mv;
    wire [9:0] phase, mval, load;
    wire [3:0] hend, hst, offp;
    wire [4:0] htop, act;
    int n_fail = 0, total_checks = 0, n;
    logic [7:0] msk [15] = '{8'h01, 8'h01, 8'h03, 8'h01, 8'h01, 8'h0F, 8'h0F, 8'h0F,
        8'h01, 8'h03, 8'h0F, 8'h03, 8'h0F, 8'h01, 8'h7F};
    int bl [4] = '{`CCAC_BLANK_C0, `CCAC_BLANK_C1, `CCAC_BLANK_C2, `CCAC_BLANK_C3};
    int dn [4] = '{32, 8, 2, 1};

    ccac_top #(.SUB_GAP(4), .SPEED_W(11)) ccac_top_inst (
        .sys_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .par_addr_i(addr), .par_wdata_i(wdata),
        .par_wr_i(wr), .par_rd_i(rd), .par_rdata_o(rdata), .par_ack_o(ack), .par_err_o(err),
        .mstep_res_i(res), .step_i(step), .dir_i(dir), .phase_pos_o(phase), .ustep_o(ustep),
        .fullstep_o(), .sw_event_i(sw_ev), .cmp_raw_i(craw), .cmp_masked_o(cmask),
        .fd_term_o(fdt), .chop_mode_o(cmode), .hyst_end_fdt_o(hend), .hyst_start_sofs_o(hst),
        .hyst_top_o(htop), .off_period_o(offp), .meas_valid_i(mv), .meas_i(mval),
        .speed_i(speed), .thr_speed_i(11'h064), .cs_max_i(5'h1F), .slowrun_cur_i(5'h0A),
        .act_cur_o(act), .adapt_active_o(aact), .load_o(load), .stall_o(stall));
    ccac_stage_model ccac_stage_model_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
        .sw_req_i(sw_req), .over_i(over), .meas_req_i(m_req), .meas_val_i(m_val),
        .sw_event_o(sw_ev), .cmp_raw_o(craw), .meas_valid_o(mv), .meas_o(mval));

    // ==========
    // shared tasks
    task chk(input logic [15:0] s, input logic [15:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %0h want %0h", $time, s, e);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    // one strobe, answer sampled two edges later
    task acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
        rq = rdata;
        re = err;
        chk(ack, 1'b1);
    endtask
    task wrp(input logic [7:0] ad, input logic [7:0] d);
        acc(1'b1, ad, d);
    endtask
    task stp(input logic v);
        step <= v;
        tick(3);
    endtask
    task meas(input logic [9:0] v);
        m_val <= v;
        m_req <= 1'b1;
        @(posedge clk);
        m_req <= 1'b0;
        tick(6);
    endtask
    task end_of_test;
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========
    // scenarios
    task t_regs;
        for (int i = 0; i < 15; i++) begin
            acc(1'b0, 8'hA0 + i[7:0], 8'h00);
            chk(rq, (i == 2) ? 8'h02 : 8'h00);
            wrp(8'hA0 + i[7:0], 8'hFF);
            acc(1'b0, 8'hA0 + i[7:0], 8'h00);
            chk(rq, msk[i]);
            wrp(8'hA0 + i[7:0], 8'h00);
        end
        acc(1'b0, 8'hAF, 8'h00);
        chk(re, 1'b1);
        chk(rq, 8'h00);
    endtask
    task t_chop;
        wrp(8'hA5, 8'h03);
        wrp(8'hA6, 8'h05);
        wrp(8'hA7, 8'h09);
        tick(2);
        chk(cmode, 1'b0);
        chk(htop, 5'h08);
        chk(hend, 4'h3);
        chk(offp, 4'h9);
        wrp(8'hA3, 8'h01);
        tick(2);
        chk(cmode, 1'b1);
        chk(htop, 5'h00);
        chk(hst, 4'h5);
        over <= 1'b1;
        wrp(8'hA4, 8'h01);
        tick(2);
        chk(cmask, 1'b1);
        chk(fdt, 1'b0);
        wrp(8'hA3, 8'h00);
        tick(2);
        chk(fdt, 1'b1);
    endtask
    task t_ce;
        ce <= 1'b0;
        wdata <= 8'h01;
        wr <= 1'b1;
        tick(2);
        chk(ack, 1'b0);
        wr <= 1'b0;
        ce <= 1'b1;
        tick(1);
        chk(cmode, 1'b0);
    endtask
    task t_blank;
        for (int c = 0; c < 4; c++) begin
            wrp(8'hA2, c[7:0]);
            sw_req <= 1'b1;
            @(posedge clk);
            sw_req <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (cmask !== 1'b1 && n < 99);
            chk(n >= bl[c] && n <= bl[c] + 2, 1'b1);
        end
        over <= 1'b0;
    endtask
    task t_step;
        for (int r = 0; r < 9; r++) begin
            res <= r[3:0];
            tick(1);
            p = phase;
            stp(1'b1);
            stp(1'b0);
            dp = phase - p;
            chk(dp, 10'h100 >> r);
        end
        wrp(8'hA1, 8'h01);
        res <= 4'h6;
        p = phase;
        stp(1'b1);
        dp = phase - p;
        chk(dp, 10'h004);
        stp(1'b0);
        dp = phase - p;
        chk(dp, 10'h008);
        wrp(8'hA1, 8'h00);
        wrp(8'hA0, 8'h01);
        res <= 4'h4;
        p = phase;
        n = 0;
        step <= 1'b1;
        repeat (80) begin
            @(posedge clk);
            if (ustep === 1'b1) n++;
        end
        dp = phase - p;
        chk(dp, 10'h010);
        chk(n[15:0], 16'h0010);
        res <= 4'h5;
        dir <= 1'b0;
        stp(1'b0);
        p = phase;
        stp(1'b1);
        dp = p - phase;
        chk(dp, 10'h008);
        wrp(8'hA0, 8'h00);
    endtask
    task t_adapt;
        speed <= 11'h032;
        tick(3);
        chk(act, 5'h0A);
        wrp(8'hAC, 8'h02);
        wrp(8'hAA, 8'h01);
        speed <= 11'h0C8;
        tick(3);
        chk(act, 5'h0F);
        expc = 5'h0F;
        for (int u = 0; u < 4; u++) begin
            wrp(8'hAB, u[7:0]);
            meas(10'h00A);
            expc = expc + (5'h01 << u);
            chk(act, expc);
        end
        meas(10'h00A);
        chk(act, 5'h1F);
        meas(10'h040);
        meas(10'h080);
        chk(act, 5'h1F);
        expc = 5'h1F;
        for (int d = 0; d < 4; d++) begin
            wrp(8'hA9, d[7:0]);
            repeat (dn[d] - 1) meas(10'h081);
            chk(act, expc);
            meas(10'h081);
            expc = expc - 5'h01;
            chk(act, expc);
        end
        wrp(8'hA8, 8'h01);
        repeat (24) meas(10'h081);
        chk(act, 5'h07);
    endtask
    task t_stall;
        wrp(8'hAE, 8'h40);
        meas(10'h3FF);
        chk(stall, 1'b1);
        chk(load, 10'h3FF);
        wrp(8'hAE, 8'h3F);
        meas(10'h000);
        chk(stall, 1'b0);
        wrp(8'hAE, 8'h00);
        meas(10'h000);
        chk(stall, 1'b1);
    endtask
    task t_filt;
        wrp(8'hAD, 8'h01);
        res <= 4'h0;
        expc = act;
        repeat (4) meas(10'h0C8);
        chk(act, expc);
        repeat (4) begin
            stp(1'b0);
            stp(1'b1);
        end
        tick(6);
        chk(act, expc - 5'h01);
    endtask

    // clock, reset and scenario sequence
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_chop;
        t_ce;
        t_blank;
        t_step;
        t_adapt;
        t_stall;
        t_filt;
        end_of_test;
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        end_of_test;
    end
endmodule
`default_nettype wire
